// ===== rtl/osc_mode_ctl.sv
// top: oscillator mode, start-up timer, internal osc enables and trim
// Functional notes
// - crystal modes count 1024 osc cycles at start
// - hold program counter while start-up timer runs
// - external clock mode skips start-up timer
// - external clock: clock from input, bit5 freed
// - fully static; clock stop keeps all state
// - crystal modes set low/medium/high amplifier gain
// - rc mode drives divided-by-4 clock out
// - rc io mode: output pin is bit4
// - internal divided_clock_output mode: input pin io, divided_clock_output
// - internal io mode frees both pins
// - fast osc enable from select and two-speed
// - control bit 2 shows fast osc stable
// - 5-bit signed trim, resets to zero
// - trim slews, settles within 1 ms, no flag
// - trim never touches slow oscillator
// - external/rc start gets short cpu delay
// - trim bits 7..5 read as zero
// - frequency select resets to 110
// - slow osc enable when select 000, scs set
// - scs cleared by reset; config mode used
// - 3-bit field picks one of eight modes
`timescale 1ns/10ps
module osc_mode_ctl
    import osc_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        osc_in_pin_i,
    input  wire logic        wake_i,
    input  wire logic        powerup_timer_done_i,
    input  wire logic        fast_osc_ready_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    output logic             cpu_hold_o,
    output logic             osc_startup_timer_done_o,
    output logic [1:0]       amp_gain_o,
    output logic             sysclk_from_pin_o,
    output logic             osc_in_pin_is_io_o,
    output logic             osc_out_pin_is_io_o,
    output logic             port_a_bit5_is_io_o,
    output logic             port_a_bit4_is_io_o,
    output logic             divided_clock_output_o,
    output logic             divided_clock_output_oe_o,
    output logic             fast_internal_osc_en_o,
    output logic             slow_internal_osc_en_o,
    output logic [TRIM_W-1:0] fast_osc_trim_o
);
    typedef struct packed {
        logic              in_s1;
        logic              in_s2;
        logic              in_s3;
        logic              powerup_timer_s1;
        logic              powerup_timer_s2;
        logic              wake_s1;
        logic              wake_s2;
        logic              wake_s3;
        logic              rdy_s1;
        logic              rdy_s2;
        logic              started;
        osc_st_t           st;
        logic [10:0]       cnt;
        logic [1:0]        div;
        logic [TRIM_W-1:0] trim;
        logic [2:0]        internal_freq_select;
        logic              sysclk_source_select;
        logic [2:0]        mode;
        logic              two_speed_enable;
        logic              powerup_timer_en;
        logic              ack;
        logic              err;
        logic [31:0]       rdat;
        logic              hold;
        logic              done;
        logic [1:0]        gain;
        logic [5:0]        pins;
        logic              clko;
        logic              clko_oe;
        logic              hf_en;
        logic              lf_en;
    } osc_top_t;

    osc_top_t r_q;
    osc_top_t r_d;
    logic [TRIM_W-1:0] trim_applied;
    logic              is_xtal;
    logic              req;
    logic              start_ev;
    logic              clk_src_rise;
    logic              divsrc;

    osc_trim_slew u_slew (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .target_i   (r_q.trim),
        .applied_o  (trim_applied)
    );

    always_comb
    begin
        r_d          = r_q;
        // mode decode
        is_xtal      = (r_q.mode == MODE_LP) || (r_q.mode == MODE_XT) || (r_q.mode == MODE_HS);
        req          = wb_cyc_i && wb_stb_i && !r_q.ack && !r_q.err;
        clk_src_rise = r_q.in_s2 && !r_q.in_s3;
        start_ev     = (!r_q.started && (!r_q.powerup_timer_en || r_q.powerup_timer_s2))
                       || (r_q.wake_s2 && !r_q.wake_s3);
        divsrc       = clk_src_rise;
        if (ce_i) // clock enable low freezes everything
        begin
            r_d.in_s1   = osc_in_pin_i;
            r_d.in_s2   = r_q.in_s1;
            r_d.in_s3   = r_q.in_s2;
            r_d.powerup_timer_s1 = powerup_timer_done_i;
            r_d.powerup_timer_s2 = r_q.powerup_timer_s1;
            r_d.wake_s1 = wake_i;
            r_d.wake_s2 = r_q.wake_s1;
            r_d.wake_s3 = r_q.wake_s2;
            r_d.rdy_s1  = fast_osc_ready_i;
            r_d.rdy_s2  = r_q.rdy_s1;
            // start-up sequencing
            if (start_ev)
            begin
                r_d.started = 1'b1;
                r_d.cnt     = 11'h000;
                if (is_xtal)
                    r_d.st = ST_OST;
                else if (r_q.mode == MODE_EC || r_q.mode == MODE_RC || r_q.mode == MODE_RC_NETWORK_IO_MODE)
                    r_d.st = ST_CPU;
                else
                    r_d.st = ST_RUN;
            end
            else
            begin
                unique case (r_q.st)
                    ST_IDLE: r_d.st = ST_IDLE;
                    ST_OST:
                    begin
                        if (clk_src_rise)
                        begin
                            if (r_q.cnt == OST_LAST)
                                r_d.st = ST_RUN;
                            else
                                r_d.cnt = r_q.cnt + 11'h001;
                        end
                    end
                    ST_CPU:
                    begin
                        if (r_q.cnt == CPU_DLY_LAST)
                            r_d.st = ST_RUN;
                        else
                            r_d.cnt = r_q.cnt + 11'h001;
                    end
                    ST_RUN:  r_d.st = ST_RUN;
                endcase
            end
            r_d.hold = (r_d.st != ST_RUN);
            r_d.done = (r_d.st == ST_RUN);
            // divide-by-4 clock source: pin for rc, internal tick otherwise
            if (r_q.mode == MODE_RC)
                divsrc = clk_src_rise;
            else
                divsrc = 1'b1;
            if (divsrc)
                r_d.div = r_q.div + 2'h1;
            r_d.clko    = r_q.div[1];
            r_d.clko_oe = (r_q.mode == MODE_RC) || (r_q.mode == MODE_INTCLK);
            // gain select
            unique case (r_q.mode)
                MODE_LP: r_d.gain = GAIN_LOW;
                MODE_XT: r_d.gain = GAIN_MED;
                MODE_HS: r_d.gain = GAIN_HIGH;
                default: r_d.gain = GAIN_OFF;
            endcase
            // pins: {sysclk_pin, in_io, out_io, bit5_io, bit4_io, unused}
            r_d.pins[5] = (r_q.mode == MODE_EC) && !r_q.sysclk_source_select;
            r_d.pins[4] = (r_q.mode == MODE_INTCLK) || (r_q.mode == MODE_INTIO);
            r_d.pins[3] = (r_q.mode == MODE_RC_NETWORK_IO_MODE) || (r_q.mode == MODE_INTIO)
                          || (r_q.mode == MODE_EC);
            r_d.pins[2] = r_d.pins[4] || (r_q.mode == MODE_EC);
            r_d.pins[1] = r_d.pins[3];
            r_d.pins[0] = 1'b0;
            // internal oscillator enables
            r_d.hf_en = (r_q.internal_freq_select != INTERNAL_FREQ_SELECT_SLOW) && (r_q.sysclk_source_select || r_q.two_speed_enable);
            r_d.lf_en = (r_q.internal_freq_select == INTERNAL_FREQ_SELECT_SLOW) && r_q.sysclk_source_select;
            // wishbone slave, one-cycle answer
            r_d.ack = 1'b0;
            r_d.err = 1'b0;
            if (req)
            begin
                unique case (wb_adr_i)
                    OSC_TRIM_ADDR:
                    begin
                        r_d.ack  = 1'b1;
                        r_d.rdat = {27'h0000000, r_q.trim};
                        if (wb_we_i && wb_sel_i[0])
                            r_d.trim = wb_dat_i[TRIM_W-1:0];
                    end
                    OSC_CTRL_ADDR:
                    begin
                        r_d.ack  = 1'b1;
                        r_d.rdat = {24'h000000, 1'b0, r_q.internal_freq_select, r_q.done && is_xtal,
                                    r_q.rdy_s2 && r_q.hf_en, 1'b0, r_q.sysclk_source_select};
                        if (wb_we_i && wb_sel_i[0])
                        begin
                            r_d.internal_freq_select = wb_dat_i[CTRL_INTERNAL_FREQ_SELECT_LSB +: 3];
                            r_d.sysclk_source_select  = wb_dat_i[CTRL_SCS_BIT];
                        end
                    end
                    OSC_CFG_ADDR:
                    begin
                        r_d.ack  = 1'b1;
                        r_d.rdat = {27'h0000000, r_q.powerup_timer_en, r_q.two_speed_enable, r_q.mode};
                        if (wb_we_i && wb_sel_i[0])
                        begin
                            r_d.mode    = wb_dat_i[CFG_MODE_LSB +: 3];
                            r_d.two_speed_enable    = wb_dat_i[CFG_TWO_SPEED_ENABLE_BIT];
                            r_d.powerup_timer_en = wb_dat_i[CFG_POWERUP_TIMER_BIT];
                        end
                    end
                    OSC_STAT_ADDR:
                    begin
                        r_d.ack  = 1'b1;
                        r_d.rdat = {24'h000000, 3'h0, r_q.hold, r_q.done,
                                    r_q.gain, r_q.st == ST_OST};
                    end
                    default:
                    begin
                        r_d.err  = 1'b1;
                        r_d.rdat = 32'h00000000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            r_q         <= '0;
            r_q.st      <= ST_IDLE;
            r_q.trim    <= TRIM_RST;
            r_q.internal_freq_select    <= INTERNAL_FREQ_SELECT_RST;
            r_q.sysclk_source_select     <= SCS_RST;
            r_q.mode    <= MODE_RST;
            r_q.hold    <= 1'b1;
            // pin already high at release is not a rising edge
            r_q.in_s1   <= 1'b1;
            r_q.in_s2   <= 1'b1;
            r_q.in_s3   <= 1'b1;
        end
        else
            r_q <= r_d;
    end

    assign wb_dat_o                  = r_q.rdat;
    assign wb_ack_o                  = r_q.ack;
    assign wb_err_o                  = r_q.err;
    assign cpu_hold_o                = r_q.hold;
    assign osc_startup_timer_done_o  = r_q.done;
    assign amp_gain_o                = r_q.gain;
    assign sysclk_from_pin_o         = r_q.pins[5];
    assign osc_in_pin_is_io_o        = r_q.pins[4];
    assign osc_out_pin_is_io_o       = r_q.pins[3];
    assign port_a_bit5_is_io_o       = r_q.pins[2];
    assign port_a_bit4_is_io_o       = r_q.pins[1];
    assign divided_clock_output_o    = r_q.clko;
    assign divided_clock_output_oe_o = r_q.clko_oe;
    assign fast_internal_osc_en_o    = r_q.hf_en;
    assign slow_internal_osc_en_o    = r_q.lf_en;
    assign fast_osc_trim_o           = trim_applied;
endmodule // osc_mode_ctl

// ===== rtl/osc_pkg.sv
// package: constants for the oscillator mode and start-up control block
package osc_pkg;
    // register byte addresses on the wishbone bus
    localparam logic [7:0] OSC_TRIM_ADDR   = 8'h90;
    localparam logic [7:0] OSC_CTRL_ADDR   = 8'h8F;
    localparam logic [7:0] OSC_CFG_ADDR    = 8'h8C;
    localparam logic [7:0] OSC_STAT_ADDR   = 8'h8D;
    // trim register
    localparam int         TRIM_W          = 5;
    localparam logic [4:0] TRIM_RST        = 5'h00;
    // control register fields
    localparam int         CTRL_SCS_BIT    = 0;
    localparam int         CTRL_HTS_BIT    = 2;
    localparam int         CTRL_OSTS_BIT   = 3;
    localparam int         CTRL_INTERNAL_FREQ_SELECT_LSB   = 4;
    localparam logic [2:0] INTERNAL_FREQ_SELECT_RST        = 3'h6;
    localparam logic [2:0] INTERNAL_FREQ_SELECT_SLOW       = 3'h0;
    localparam logic       SCS_RST         = 1'b0;
    // config register fields
    localparam int         CFG_MODE_LSB    = 0;
    localparam int         CFG_TWO_SPEED_ENABLE_BIT    = 3;
    localparam int         CFG_POWERUP_TIMER_BIT    = 4;
    localparam logic [2:0] MODE_RST        = 3'h0;
    // clock modes
    localparam logic [2:0] MODE_LP         = 3'h0;
    localparam logic [2:0] MODE_XT         = 3'h1;
    localparam logic [2:0] MODE_HS         = 3'h2;
    localparam logic [2:0] MODE_EC         = 3'h3;
    localparam logic [2:0] MODE_INTIO      = 3'h4;
    localparam logic [2:0] MODE_INTCLK     = 3'h5;
    localparam logic [2:0] MODE_RC_NETWORK_IO_MODE       = 3'h6;
    localparam logic [2:0] MODE_RC         = 3'h7;
    // gain settings
    localparam logic [1:0] GAIN_OFF        = 2'h0;
    localparam logic [1:0] GAIN_LOW        = 2'h1;
    localparam logic [1:0] GAIN_MED        = 2'h2;
    localparam logic [1:0] GAIN_HIGH       = 2'h3;
    // timing
    localparam int         OST_CYCLES      = 1024;
    localparam logic [10:0] OST_LAST       = 11'(OST_CYCLES - 1);
    localparam int         CLK_MHZ         = 125;
    localparam int         CPU_DLY_US      = 5;
    localparam int         CPU_DLY_CYC     = CPU_DLY_US * CLK_MHZ;
    localparam logic [10:0] CPU_DLY_LAST   = 11'(CPU_DLY_CYC - 1);
    localparam int         TRIM_SETTLE_MS  = 1;
    localparam int         TRIM_SETTLE_CYC = TRIM_SETTLE_MS * 1000 * CLK_MHZ;
    localparam int         TRIM_STEP_CYC   = TRIM_SETTLE_CYC / 32;
    localparam logic [11:0] TRIM_STEP_LAST = 12'(TRIM_STEP_CYC - 1);
    typedef enum logic [1:0] {ST_IDLE, ST_OST, ST_CPU, ST_RUN} osc_st_t;
endpackage

// ===== rtl/osc_trim_slew.sv
// trim slew: walks the applied trim toward the written value
`timescale 1ns/10ps
module osc_trim_slew
    import osc_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    input  wire logic [TRIM_W-1:0] target_i,
    output logic      [TRIM_W-1:0] applied_o
);
    typedef struct packed {
        logic [TRIM_W-1:0] cur;
        logic [11:0]       tick;
    } osc_slew_t;

    osc_slew_t s_q;
    osc_slew_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (ce_i)
        begin
            if (s_q.cur == target_i)
                s_d.tick = 12'h000;
            else if (s_q.tick == TRIM_STEP_LAST)
            begin
                s_d.tick = 12'h000;
                // one signed step per tick, settles within the window
                if ($signed(target_i) > $signed(s_q.cur))
                    s_d.cur = s_q.cur + 5'h01;
                else
                    s_d.cur = s_q.cur - 5'h01;
            end
            else
                s_d.tick = s_q.tick + 12'h001;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            s_q <= '{cur: TRIM_RST, tick: 12'h000};
        else
            s_q <= s_d;
    end

    assign applied_o = s_q.cur;
endmodule // osc_trim_slew

// ===== sim/osc_src_model.sv
// model: external oscillator source on the input pin
`timescale 1ns/10ps
module osc_src_model
(
    input  wire logic core_clk_i,
    input  wire logic run_i,
    output logic      osc_o
);
    logic [1:0] div_q = 2'h0;
    initial osc_o = 1'b0;
    // half period of three core cycles, stands low when stopped
    always @(posedge core_clk_i)
    begin
        if (!run_i)
        begin
            osc_o <= 1'b0;
            div_q <= 2'h0;
        end
        else if (div_q == 2'h2)
        begin
            osc_o <= ~osc_o;
            div_q <= 2'h0;
        end
        else
            div_q <= div_q + 2'h1;
    end
endmodule // osc_src_model

// ===== sim/osc_mode_ctl_sva.sv
// checker: port assertions of the oscillator control block
`timescale 1ns/10ps
module osc_mode_ctl_sva
    import osc_pkg::*;
(
    input wire logic              core_clk_i,
    input wire logic              rst_i,
    input wire logic              ce_i,
    input wire logic              osc_in_pin_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_ack_o,
    input wire logic              wb_err_o,
    input wire logic              cpu_hold_o,
    input wire logic              osc_startup_timer_done_o,
    input wire logic [1:0]        amp_gain_o,
    input wire logic              sysclk_from_pin_o,
    input wire logic              osc_in_pin_is_io_o,
    input wire logic              osc_out_pin_is_io_o,
    input wire logic              port_a_bit5_is_io_o,
    input wire logic              port_a_bit4_is_io_o,
    input wire logic              divided_clock_output_oe_o,
    input wire logic              fast_internal_osc_en_o,
    input wire logic              slow_internal_osc_en_o,
    input wire logic [TRIM_W-1:0] fast_osc_trim_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic        osc_q;
    logic [11:0] edg_q;
    // raw input edges seen while execution is held
    always_ff @(posedge core_clk_i)
    begin
        osc_q <= osc_in_pin_i;
        if (rst_i || !cpu_hold_o)
            edg_q <= 12'h000;
        else if (osc_in_pin_i && !osc_q && edg_q != 12'hFFF)
            edg_q <= edg_q + 12'h001;
    end
    sequence s_taken;
        wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence s_answer;
        (wb_ack_o || wb_err_o) ##1 !(wb_ack_o || wb_err_o);
    endsequence
    AST_BUS_ANSWER: assert property (s_taken |=> s_answer)
        else $error("bus answer late or long");
    AST_OST_COUNT: assert property ($fell(cpu_hold_o) && amp_gain_o != GAIN_OFF
        |-> edg_q >= 12'(OST_CYCLES))
        else $error("crystal start released early");
    AST_HOLD_DONE: assert property (cpu_hold_o != osc_startup_timer_done_o)
        else $error("hold and done disagree");
    AST_FREEZE: assert property (!ce_i && !$past(rst_i) |=> $stable(fast_osc_trim_o)
        && $stable(cpu_hold_o) && $stable(amp_gain_o))
        else $error("state moved with clock stopped");
    AST_TRIM_STEP: assert property ($changed(fast_osc_trim_o) |->
        5'(fast_osc_trim_o - $past(fast_osc_trim_o)) inside {5'h01, 5'h1F})
        else $error("trim jumped");
    AST_EXT_PINS: assert property (sysclk_from_pin_o |-> port_a_bit5_is_io_o
        && !osc_in_pin_is_io_o && amp_gain_o == GAIN_OFF)
        else $error("external clock pins wrong");
    AST_BIT4: assert property (port_a_bit4_is_io_o == osc_out_pin_is_io_o
        && !(osc_out_pin_is_io_o && (divided_clock_output_oe_o || amp_gain_o != GAIN_OFF)))
        else $error("bit4 use mismatch");
    AST_DIVIDED_CLOCK_OUTPUT: assert property (divided_clock_output_oe_o |-> !osc_out_pin_is_io_o)
        else $error("clock out on io pin");
    AST_INT_PINS: assert property (osc_in_pin_is_io_o |-> amp_gain_o == GAIN_OFF
        && port_a_bit5_is_io_o)
        else $error("internal mode pins wrong");
    AST_OSC_EN: assert property (!(fast_internal_osc_en_o && slow_internal_osc_en_o))
        else $error("both internal oscs on");
endmodule // osc_mode_ctl_sva
bind osc_mode_ctl osc_mode_ctl_sva osc_mode_ctl_sva_i (.core_clk_i, .rst_i, .ce_i,
    .osc_in_pin_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o, .cpu_hold_o,
    .osc_startup_timer_done_o, .amp_gain_o, .sysclk_from_pin_o, .osc_in_pin_is_io_o,
    .osc_out_pin_is_io_o, .port_a_bit5_is_io_o, .port_a_bit4_is_io_o,
    .divided_clock_output_oe_o, .fast_internal_osc_en_o, .slow_internal_osc_en_o,
    .fast_osc_trim_o);

// ===== sim/osc_mode_ctl_tb_top.sv
// testbench: registers, start-up and pin modes of the oscillator block
`timescale 1ns/10ps
module osc_mode_ctl_tb_top
    import osc_pkg::*;
;
    localparam logic [5:0] PIN_EXP [8] = '{6'h00, 6'h00, 6'h00, 6'h2E, 6'h1E, 6'h15, 6'h0A, 6'h01};
    localparam logic [1:0] GAIN_EXP [8] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
    localparam logic [7:0] EN_CFG [4] = '{8'h03, 8'h03, 8'h03, 8'h0B};
    localparam logic [7:0] EN_CTL [4] = '{8'h61, 8'h01, 8'h60, 8'h60};
    localparam logic [1:0] EN_EXP [4] = '{2'h2, 2'h1, 2'h0, 2'h2};
    localparam logic [7:0] TR_W [3] = '{8'h0F, 8'h10, 8'hFF};
    localparam logic [7:0] TR_R [3] = '{8'h0F, 8'h10, 8'h1F};
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic run = 1'b1;
    logic wake_i = 1'b0;
    logic powerup_timer_done_i = 1'b0;
    logic fast_osc_ready_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, wb_err_o, cpu_hold_o, osc_startup_timer_done_o, osc_in_pin_i;
    logic [1:0] amp_gain_o;
    logic sysclk_from_pin_o, osc_in_pin_is_io_o, osc_out_pin_is_io_o, port_a_bit5_is_io_o;
    logic port_a_bit4_is_io_o, divided_clock_output_o, divided_clock_output_oe_o;
    logic fast_internal_osc_en_o, slow_internal_osc_en_o;
    logic [TRIM_W-1:0] fast_osc_trim_o;
    int err_count = 0;
    int checks = 0;
    int cyc_n = 0;
    osc_src_model osc_src_model_i (.core_clk_i, .run_i(run), .osc_o(osc_in_pin_i));
    osc_mode_ctl osc_mode_ctl_i (.core_clk_i, .rst_i, .ce_i, .osc_in_pin_i, .wake_i,
        .powerup_timer_done_i, .fast_osc_ready_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .cpu_hold_o,
        .osc_startup_timer_done_o, .amp_gain_o, .sysclk_from_pin_o, .osc_in_pin_is_io_o,
        .osc_out_pin_is_io_o, .port_a_bit5_is_io_o, .port_a_bit4_is_io_o,
        .divided_clock_output_o, .divided_clock_output_oe_o, .fast_internal_osc_en_o,
        .slow_internal_osc_en_o, .fast_osc_trim_o);
    initial forever #4 core_clk_i = ~core_clk_i;
    task automatic wrap_up();
        if (err_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q, output logic e);
        @(posedge core_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do
        begin
            @(posedge core_clk_i);
        end
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        q = wb_dat_o;
        e = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        wb(1'b1, a, {24'h0, d}, 4'hF, q, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        wb(1'b0, a, 32'h0, 4'hF, q, e);
    endtask
    task automatic wait_hold(input logic v, input int lim, output int n);
        n = 0;
        while (cpu_hold_o !== v && n < lim)
        begin
            @(posedge core_clk_i);
            n++;
        end
    endtask
    always @(posedge core_clk_i)
    begin
        cyc_n++;
        if (cyc_n == 60000)
        begin
            err_count++;
            wrap_up();
        end
    end
    initial
    begin
        logic [31:0] q;
        logic        e;
        logic        dp;
        int          n;
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        rd(OSC_TRIM_ADDR, q);
        chk(q, 32'h0);
        rd(OSC_CTRL_ADDR, q);
        chk(q & 32'h71, 32'h60);
        rd(OSC_CFG_ADDR, q);
        chk(q & 32'h7, 32'h0);
        wb(1'b0, 8'h00, 32'h0, 4'hF, q, e);
        chk(e, 32'h1);
        repeat (5000) @(posedge core_clk_i);
        chk(cpu_hold_o, 32'h1);
        wait_hold(1'b0, 3000, n);
        chk(n > 1000 && n < 1400, 32'h1);
        chk(osc_startup_timer_done_o, 32'h1);
        for (int m = 0; m < 8; m++)
        begin
            wr(OSC_CFG_ADDR, 8'(m));
            repeat (3) @(posedge core_clk_i);
            rd(OSC_STAT_ADDR, q);
            chk(q[2:1], GAIN_EXP[m]);
            chk(amp_gain_o, GAIN_EXP[m]);
            chk({sysclk_from_pin_o, osc_in_pin_is_io_o, osc_out_pin_is_io_o, port_a_bit5_is_io_o,
                port_a_bit4_is_io_o, divided_clock_output_oe_o}, PIN_EXP[m]);
        end
        n = 0;
        dp = divided_clock_output_o;
        repeat (240)
        begin
            @(posedge core_clk_i);
            if (divided_clock_output_o === 1'b1 && dp === 1'b0)
                n++;
            dp = divided_clock_output_o;
        end
        chk(n >= 9 && n <= 11, 32'h1);
        wr(OSC_CFG_ADDR, {5'h0, MODE_EC});
        wake_i <= 1'b1;
        wait_hold(1'b1, 20, n);
        chk(n < 20, 32'h1);
        wake_i <= 1'b0;
        wait_hold(1'b0, 1000, n);
        chk(n >= CPU_DLY_CYC - 5 && n <= CPU_DLY_CYC + 5, 32'h1);
        run <= 1'b0;
        fast_osc_ready_i <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            wr(OSC_CFG_ADDR, EN_CFG[i]);
            wr(OSC_CTRL_ADDR, EN_CTL[i]);
            repeat (4) @(posedge core_clk_i);
            rd(OSC_CTRL_ADDR, q);
            chk({fast_internal_osc_en_o, slow_internal_osc_en_o}, EN_EXP[i]);
            chk(q[2], EN_EXP[i][1]);
            chk(sysclk_from_pin_o, !EN_CTL[i][0]);
        end
        fast_osc_ready_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        rd(OSC_CTRL_ADDR, q);
        chk(q[2], 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            wr(OSC_TRIM_ADDR, TR_W[i]);
            rd(OSC_TRIM_ADDR, q);
            chk(q, {24'h0, TR_R[i]});
        end
        wb(1'b1, OSC_TRIM_ADDR, 32'h05, 4'h0, q, e);
        rd(OSC_TRIM_ADDR, q);
        chk(q, 32'h1F);
        wr(OSC_TRIM_ADDR, 8'h02);
        ce_i <= 1'b0;
        repeat (50) @(posedge core_clk_i);
        ce_i <= 1'b1;
        n = 0;
        while (fast_osc_trim_o !== 5'h02 && n < 20000)
        begin
            @(posedge core_clk_i);
            n++;
        end
        chk(fast_osc_trim_o, 32'h02);
        wrap_up();
    end
endmodule // osc_mode_ctl_tb_top
